/* logic/spi_pin_sync.sv */
// Purpose: bring the serial pins into the mclk domain and find their edges
// Assumes: pins are asynchronous to mclk
// Notes: edges are found on the second stage only
`timescale 1ns/1ps
module spi_pin_sync #(
    parameter int W = 3
) (
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    // pins
    input wire logic [W-1:0] pinsIn,
    // synchronised levels and edges
    output logic [W-1:0] syncLvl,
    output logic [W-1:0] rise,
    output logic [W-1:0] fall
);
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            logic meta_q;
            logic stable_q;
            logic last_q;
            always_ff @(posedge mclk) begin
                if (reset) begin
                    meta_q <= 1'b0;
                    stable_q <= 1'b0;
                    last_q <= 1'b0;
                end else begin
                    meta_q <= pinsIn[i];
                    stable_q <= meta_q;
                    last_q <= stable_q;
                end
            end
            assign syncLvl[i] = stable_q;
            assign rise[i] = stable_q & ~last_q;
            assign fall[i] = ~stable_q & last_q;
        end
    endgenerate
endmodule // spi_pin_sync

/* logic/spi_register_port.sv */
// Purpose: four-wire serial slave giving a host access to paged registers
// Assumes: mclk far faster than the serial clock; chip enable active high
// Notes: local port shares the register store; serial writes win a clash
//
// Functional notes
// - slave-only access to all configuration registers
// - data output released except during read data
// - all fields shifted most significant bit first
// - direction bit, then page, then register address
// - burst flag: zero single, one burst
// - four pad bits, then eight data bits
// - never drive the output during writes
// - fetch during pad bits, valid from first bit
// - burst continues while chip enable stays high
// - burst address increments by one per byte
// - partial byte at frame end is discarded
// - pages of 256 byte locations chosen by page
// - unimplemented locations read back as all ones
// - pins serve this port only when strapped
`timescale 1ns/1ps
module spi_register_port #(
    parameter int PAGE_W = spi_port_pkg::PAGE_W_DEFAULT,
    parameter int IMPL_W = spi_port_pkg::IMPL_W_DEFAULT
) (
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    // factory interface choice, high selects the serial port
    input wire logic factorySpiMode,
    // shared serial pins
    input wire logic sharedPinSelect,
    input wire logic sharedPinClock,
    input wire logic sharedPinDataIn,
    output logic sharedPinDataOut,
    output logic sharedPinDataOutEn,
    // local register port
    input wire logic [PAGE_W+spi_port_pkg::ADDR_W-1:0] locAddr,
    input wire logic [7:0] locWdata,
    input wire logic locWrite,
    input wire logic locRead,
    output logic [7:0] locRdata
);
    // =====================================================================
    // sizes
    localparam int HDR_BITS = 2 + PAGE_W + spi_port_pkg::ADDR_W;
    localparam int CNT_W = $clog2(HDR_BITS) + 1;
    localparam int IDX_W = PAGE_W + IMPL_W;
    localparam int DEPTH = 2 ** IDX_W;
    localparam logic [CNT_W-1:0] HDR_LAST = CNT_W'(HDR_BITS - 1);
    localparam logic [CNT_W-1:0] PAD_LAST = CNT_W'(spi_port_pkg::PAD_BITS - 1);
    localparam logic [CNT_W-1:0] DATA_LAST = CNT_W'(spi_port_pkg::DATA_BITS - 1);

    logic [7:0] regMem [DEPTH];
    spi_port_pkg::frame_state_t state_q;
    logic [CNT_W-1:0] bitCnt_q;
    logic [HDR_BITS-2:0] hdrShift_q;
    logic [6:0] dataShift_q;
    logic [7:0] txShift_q;
    logic dir_q;
    logic burst_q;
    logic [PAGE_W-1:0] page_q;
    logic [7:0] addr_q;
    logic spiMode_q;
    logic strapDone_q;
    logic [2:0] syncLvl;
    logic [2:0] syncRise;
    logic [2:0] syncFall;
    logic selLvl;
    logic sckRise;
    logic sckFall;
    logic dataInLvl;
    logic [HDR_BITS-1:0] hdrFull;
    logic hdrEnd;
    logic padEnd;
    logic byteEnd;
    logic spiWe;
    logic [7:0] fetchAddr;
    logic [7:0] readByte;

    // =====================================================================
    // pin synchronisers
    spi_pin_sync #(
        .W(3)
    ) u_sync (
        .mclk(mclk),
        .reset(reset),
        .pinsIn({sharedPinSelect, sharedPinClock, sharedPinDataIn}),
        .syncLvl(syncLvl),
        .rise(syncRise),
        .fall(syncFall)
    );

    assign selLvl = syncLvl[2] & spiMode_q;
    assign sckRise = syncRise[1] & selLvl;
    assign sckFall = syncFall[1] & selLvl;
    assign dataInLvl = syncLvl[0];
    assign hdrFull = {hdrShift_q, dataInLvl};
    assign hdrEnd = sckRise && state_q == spi_port_pkg::HEADER && bitCnt_q == HDR_LAST;
    assign padEnd = sckRise && state_q == spi_port_pkg::FETCH && bitCnt_q == PAD_LAST;
    assign byteEnd = sckRise && state_q == spi_port_pkg::DATA && bitCnt_q == DATA_LAST;

    // =====================================================================
    // factory strap, caught once after reset release
    always_ff @(posedge mclk) begin
        if (reset) begin
            spiMode_q <= 1'b0;
            strapDone_q <= 1'b0;
        end else if (!strapDone_q) begin
            spiMode_q <= factorySpiMode;
            strapDone_q <= 1'b1;
        end
    end

    // =====================================================================
    // frame sequencer
    always_ff @(posedge mclk) begin
        if (reset || !selLvl) begin
            state_q <= spi_port_pkg::HEADER;
            bitCnt_q <= '0;
        end else if (sckRise) begin
            unique case (state_q)
                spi_port_pkg::HEADER: begin
                    if (bitCnt_q == HDR_LAST) begin
                        state_q <= spi_port_pkg::FETCH;
                        bitCnt_q <= '0;
                    end else begin
                        bitCnt_q <= bitCnt_q + 1'b1;
                    end
                end
                spi_port_pkg::FETCH: begin
                    if (bitCnt_q == PAD_LAST) begin
                        state_q <= spi_port_pkg::DATA;
                        bitCnt_q <= '0;
                    end else begin
                        bitCnt_q <= bitCnt_q + 1'b1;
                    end
                end
                spi_port_pkg::DATA: begin
                    if (bitCnt_q == DATA_LAST) begin
                        bitCnt_q <= '0;
                        if (burst_q == spi_port_pkg::BURST_ON) begin
                            state_q <= spi_port_pkg::DATA;
                        end else begin
                            state_q <= spi_port_pkg::DONE;
                        end
                    end else begin
                        bitCnt_q <= bitCnt_q + 1'b1;
                    end
                end
                spi_port_pkg::DONE: begin
                    state_q <= spi_port_pkg::DONE;
                end
            endcase
        end
    end

    // =====================================================================
    // header and data shifters, msb first
    always_ff @(posedge mclk) begin
        if (reset || !selLvl) begin
            hdrShift_q <= '0;
            dataShift_q <= '0;
        end else if (sckRise) begin
            if (state_q == spi_port_pkg::HEADER) begin
                hdrShift_q <= hdrFull[HDR_BITS-2:0];
            end
            if (state_q == spi_port_pkg::DATA) begin
                dataShift_q <= {dataShift_q[5:0], dataInLvl};
            end
        end
    end

    // =====================================================================
    // frame fields and burst address
    always_ff @(posedge mclk) begin
        if (reset || !selLvl) begin
            dir_q <= spi_port_pkg::DIR_READ;
            burst_q <= 1'b0;
            page_q <= '0;
            addr_q <= '0;
        end else if (hdrEnd) begin
            dir_q <= hdrFull[HDR_BITS-1];
            page_q <= hdrFull[HDR_BITS-2 -: PAGE_W];
            addr_q <= hdrFull[spi_port_pkg::ADDR_W:1];
            burst_q <= hdrFull[0];
        end else if (byteEnd && burst_q == spi_port_pkg::BURST_ON) begin
            addr_q <= addr_q + 8'h01;
        end
    end

    // =====================================================================
    // register fetch, unimplemented locations read as all ones
    always_comb begin
        fetchAddr = (state_q == spi_port_pkg::FETCH) ? addr_q : addr_q + 8'h01;
        if ((fetchAddr >> IMPL_W) == 8'h00) begin
            readByte = regMem[{page_q, fetchAddr[IMPL_W-1:0]}];
        end else begin
            readByte = spi_port_pkg::UNMAPPED_VALUE;
        end
    end

    // =====================================================================
    // read data out: loaded on a rise, driven on the following falls
    always_ff @(posedge mclk) begin
        if (reset || !selLvl) begin
            txShift_q <= '0;
            sharedPinDataOut <= 1'b0;
            sharedPinDataOutEn <= 1'b0;
        end else begin
            if (padEnd || (byteEnd && burst_q == spi_port_pkg::BURST_ON)) begin
                txShift_q <= readByte;
            end else if (sckFall && state_q == spi_port_pkg::DATA) begin
                txShift_q <= {txShift_q[6:0], 1'b1};
            end
            if (sckFall && state_q == spi_port_pkg::DATA && dir_q == spi_port_pkg::DIR_READ) begin
                sharedPinDataOut <= txShift_q[7];
                sharedPinDataOutEn <= 1'b1;
            end else if (sckFall && state_q == spi_port_pkg::DONE) begin
                sharedPinDataOutEn <= 1'b0;
            end
        end
    end

    // =====================================================================
    // register store, written only by whole bytes
    assign spiWe = byteEnd && dir_q == spi_port_pkg::DIR_WRITE && (addr_q >> IMPL_W) == 8'h00;

    always_ff @(posedge mclk) begin
        if (reset) begin
            for (int k = 0; k < DEPTH; k++) begin
                regMem[k] <= spi_port_pkg::RESET_VALUE;
            end
        end else if (spiWe) begin
            regMem[{page_q, addr_q[IMPL_W-1:0]}] <= {dataShift_q, dataInLvl};
        end else if (locWrite && (locAddr[7:0] >> IMPL_W) == 8'h00) begin
            regMem[{locAddr[PAGE_W+7:8], locAddr[IMPL_W-1:0]}] <= locWdata;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            locRdata <= 8'h00;
        end else if (locRead) begin
            if ((locAddr[7:0] >> IMPL_W) == 8'h00) begin
                locRdata <= regMem[{locAddr[PAGE_W+7:8], locAddr[IMPL_W-1:0]}];
            end else begin
                locRdata <= spi_port_pkg::UNMAPPED_VALUE;
            end
        end
    end

    // =====================================================================
    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    sequence byteDone_s;
        byteEnd;
    endsequence

    sequence readFall_s;
        sckFall && state_q == spi_port_pkg::DATA && dir_q == spi_port_pkg::DIR_READ;
    endsequence

    write_no_drive_a: assert property (
        sharedPinDataOutEn |-> dir_q == spi_port_pkg::DIR_READ)
        else $error("output driven outside a read");

    release_on_drop_a: assert property (
        !selLvl |=> !sharedPinDataOutEn && state_q == spi_port_pkg::HEADER)
        else $error("output not released after chip enable drop");

    clear_partial_a: assert property (
        $fell(selLvl) |=> bitCnt_q == '0 && hdrShift_q == '0 && dataShift_q == '0)
        else $error("partial frame not cleared");

    whole_byte_a: assert property (
        spiWe |-> selLvl && state_q == spi_port_pkg::DATA && bitCnt_q == DATA_LAST)
        else $error("store written by a partial byte");

    burst_step_a: assert property (
        byteDone_s ##0 burst_q |=> addr_q == $past(addr_q) + 8'h01)
        else $error("burst address did not advance by one");

    single_end_a: assert property (
        byteDone_s ##0 !burst_q |=> state_q == spi_port_pkg::DONE [*2])
        else $error("single access did not end");

    pad_count_a: assert property (
        hdrEnd |=> state_q == spi_port_pkg::FETCH && bitCnt_q == '0)
        else $error("pad phase not entered after header");

    msb_drive_a: assert property (
        readFall_s |=> sharedPinDataOutEn && sharedPinDataOut == $past(txShift_q[7]))
        else $error("read bit not driven on the fall");

    strap_gate_a: assert property (
        !spiMode_q |-> !sharedPinDataOutEn && state_q == spi_port_pkg::HEADER)
        else $error("port active without strap");

    unmapped_a: assert property (
        locRead && (locAddr[7:0] >> IMPL_W) != 8'h00 |=> locRdata == 8'hff)
        else $error("unmapped location did not read all ones");
endmodule // spi_register_port

/* shared/spi_port_pkg.sv */
// Purpose: shared constants and types of the serial register access port
// Assumes: frames of direction, page, register address, burst flag, pad bits, data bytes
// Notes: the register address field covers one 256-location page
package spi_port_pkg;
    // =====================================================================
    // frame layout
    localparam int ADDR_W = 8;
    localparam int DATA_BITS = 8;
    localparam int PAD_BITS = 4;
    localparam int PAGE_W_DEFAULT = 2;
    localparam int IMPL_W_DEFAULT = 6;
    localparam logic DIR_READ = 1'b0;
    localparam logic DIR_WRITE = 1'b1;
    localparam logic BURST_ON = 1'b1;
    // =====================================================================
    // values
    localparam logic [7:0] UNMAPPED_VALUE = 8'hff;
    localparam logic [7:0] RESET_VALUE = 8'h00;
    // =====================================================================
    // frame sequencer
    typedef enum logic [1:0] {
        HEADER,
        FETCH,
        DATA,
        DONE
    } frame_state_t;
endpackage

/* verif/spi_host_model.sv */
// Purpose: host master model driving frames into the serial register port
// Assumes: serial clock made from mclk, 12 cycles high and 13 low (125 ns)
// Notes: counts output enable faults in badEn for the bench to inspect
`timescale 1ns/1ps
module spi_host_model (
    // clock
    input wire logic mclk,
    // lines to the device
    output logic chipSel,
    output logic serClk,
    output logic serIn,
    // lines from the device
    input wire logic serOut,
    input wire logic serOutEn
);
    int badEn;
    initial begin
        chipSel = 1'b0;
        serClk = 1'b0;
        serIn = 1'b0;
        badEn = 0;
    end
    // =====================================================================
    // frame: 12 header bits, 4 pad bits, nBits data bits; clock idles low
    task automatic frame(input logic [11:0] hdr, input int nBits, input logic [7:0] wq[$],
                         input logic drive, output logic [7:0] rq[$]);
        logic [7:0] rb;
        logic b;
        int total;
        total = 16 + nBits;
        rq = {};
        @(posedge mclk) chipSel <= 1'b1;
        repeat (4) @(posedge mclk);
        for (int i = 0; i < total; i++) begin
            b = (i < 12) ? hdr[11-i] : (i < 16) ? i[0] : wq[(i-16)/8][7-(i-16)%8];
            serIn <= b;
            repeat (13) @(posedge mclk);
            serClk <= 1'b1;
            if (serOutEn !== (drive && i >= 16)) badEn++;
            rb = {rb[6:0], serOutEn ? serOut : ~serOut}; // released line seen as inverse
            if (i >= 16 && (i - 15) % 8 == 0) rq.push_back(rb);
            repeat (12) @(posedge mclk);
            serClk <= 1'b0;
        end
        repeat (6) @(posedge mclk);
        chipSel <= 1'b0;
        serIn <= ~serIn;
        repeat (8) @(posedge mclk);
        if (serOutEn !== 1'b0) badEn++;
    endtask
endmodule // spi_host_model

/* verif/spi_slave_register_access_test.sv */
// Purpose: self-checking bench of the serial register port
// Assumes: PAGE_W 2, IMPL_W 6, so locations 0..63 of each page exist
// Notes: a reference store follows every accepted write
`timescale 1ns/1ps
module spi_slave_register_access_test;
    localparam int IMPL = 6;
    logic mclk, reset, strap, sel, sck, hostData, devData, devDataEn, locWrite, locRead;
    logic [9:0] locAddr, a;
    logic [7:0] locWdata, locRdata;
    logic [7:0] mem [0:1023];
    logic [7:0] wq[$];
    logic [7:0] rq[$];
    int errTotal, comparisons;

    spi_register_port #(.PAGE_W(2), .IMPL_W(IMPL)) i_dut (
        .mclk(mclk), .reset(reset), .factorySpiMode(strap), .sharedPinSelect(sel),
        .sharedPinClock(sck), .sharedPinDataIn(hostData), .sharedPinDataOut(devData),
        .sharedPinDataOutEn(devDataEn), .locAddr(locAddr), .locWdata(locWdata),
        .locWrite(locWrite), .locRead(locRead), .locRdata(locRdata));
    spi_host_model i_host (.mclk(mclk), .chipSel(sel), .serClk(sck), .serIn(hostData),
        .serOut(devData), .serOutEn(devDataEn));

    // =====================================================================
    // helpers
    function automatic logic [7:0] expect8(input logic [9:0] ad);
        return (int'(ad[7:0]) < (1 << IMPL)) ? mem[ad] : spi_port_pkg::UNMAPPED_VALUE;
    endfunction
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            errTotal++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic locWr(input logic [9:0] ad, input logic [7:0] d);
        @(posedge mclk);
        locAddr <= ad;
        locWdata <= d;
        locWrite <= 1'b1;
        @(posedge mclk);
        locWrite <= 1'b0;
        if (int'(ad[7:0]) < (1 << IMPL)) mem[ad] = d;
    endtask
    task automatic locRd(input logic [9:0] ad);
        @(posedge mclk);
        locAddr <= ad;
        locRead <= 1'b1;
        @(posedge mclk);
        locRead <= 1'b0;
        #1;
        chk("local read", expect8(ad), locRdata);
    endtask
    task automatic spi(input logic dir, input logic [9:0] ad, input logic burst, input int nBits);
        logic [9:0] p;
        wq = {};
        for (int k = 0; k < (nBits + 7) / 8; k++) wq.push_back(8'($urandom));
        i_host.frame({dir, ad, burst}, nBits, wq, !dir && strap, rq);
        for (int k = 0; k < nBits / 8; k++) begin
            p = {ad[9:8], 8'(ad[7:0] + 8'(k))};
            if (dir == spi_port_pkg::DIR_READ) chk("serial read", expect8(p), rq[k]);
            else if (strap && int'(p[7:0]) < (1 << IMPL)) mem[p] = wq[k];
        end
        chk("output enable faults", 8'h00, 8'(i_host.badEn));
        i_host.badEn = 0;
    endtask
    task automatic doReset(input logic s);
        @(posedge mclk);
        strap <= s;
        reset <= 1'b1;
        repeat (8) @(posedge mclk);
        reset <= 1'b0;
        for (int k = 0; k < 1024; k++) mem[k] = spi_port_pkg::RESET_VALUE;
        repeat (8) @(posedge mclk);
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", comparisons, errTotal);
        if (errTotal == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // =====================================================================
    // clock, watchdog and main sequence
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    initial begin
        repeat (90000) @(posedge mclk);
        errTotal++;
        summarize();
    end
    initial begin
        reset = 1'b1;
        strap = 1'b0;
        locAddr = '0;
        locWdata = '0;
        locWrite = 1'b0;
        locRead = 1'b0;
        errTotal = 0;
        comparisons = 0;
        void'($urandom(51188));
        doReset(1'b0);
        spi(spi_port_pkg::DIR_WRITE, 10'h005, 1'b0, 8);
        locRd(10'h005);
        doReset(1'b1);
        locRd(10'h3ff);
        for (int n = 0; n < 8; n++) begin
            a = 10'($urandom) & ((n < 6) ? 10'h33f : 10'h3ff);
            spi(spi_port_pkg::DIR_WRITE, a, 1'b0, 8);
            spi(spi_port_pkg::DIR_READ, a, 1'b0, 8);
            locRd(a);
            locWr(a ^ 10'h100, 8'($urandom));
            spi(spi_port_pkg::DIR_READ, a ^ 10'h100, 1'b0, 8);
        end
        spi(spi_port_pkg::DIR_WRITE, 10'h13e, spi_port_pkg::BURST_ON, 32);
        spi(spi_port_pkg::DIR_READ, 10'h13d, spi_port_pkg::BURST_ON, 40);
        spi(spi_port_pkg::DIR_WRITE, 10'h2fe, spi_port_pkg::BURST_ON, 24);
        locRd(10'h200);
        spi(spi_port_pkg::DIR_WRITE, 10'h210, spi_port_pkg::BURST_ON, 21);
        spi(spi_port_pkg::DIR_READ, 10'h210, spi_port_pkg::BURST_ON, 24);
        spi(spi_port_pkg::DIR_WRITE, 10'h020, 1'b0, 5);
        locRd(10'h020);
        i_host.frame(12'hfff, -9, wq, 1'b0, rq);
        spi(spi_port_pkg::DIR_WRITE, 10'h001, 1'b0, 8);
        spi(spi_port_pkg::DIR_READ, 10'h001, 1'b0, 8);
        summarize();
    end
endmodule // spi_slave_register_access_test
